// ### pkg/ntc_defs.svh
// offsets, field positions, reset values and timing counts of the transfer decoder
// assumes inclusion by bare name from the package and from the design file
`ifndef NTC_DEFS_SVH
`define NTC_DEFS_SVH
// register word offsets on the plain register port
`define OFS_CW0 4'h0
`define OFS_CW1 4'h1
`define OFS_CW2 4'h2
`define OFS_SRC 4'h3
`define OFS_DST 4'h4
`define OFS_NODE 4'h5
`define OFS_AREA 4'h6
`define OFS_CMD 4'h7
`define OFS_STAT 4'h8
// second control word field positions
`define CW1_RTY_LO 8
`define CW1_IND 12
`define CW1_NORSP 13
`define CW1_LVL0 14
`define CW1_NET 15
// reset values
`define RST_CW1 16'h8000
`define RST_WORD 16'h0000
// limits
`define MAX_WORDS 16'h0100
`define MAX_NODE 8'h3E
`define MAX_UNIT 5'h04
`define TMO_NONE 8'hFF
// timing: clock in kHz, tick and default time-out in ms
`define CLK_KHZ 125000
`define TICK_MS 100
`define DEF_TMO_MS 2000
// result codes
`define RC_OK 8'h00
`define RC_PARAM 8'h01
`define RC_RANGE 8'h02
`define RC_TMO 8'h03
`define RC_SELF 8'h04
// remote area codes
`define AC_IO 8'h00
`define AC_TC 8'h03
`define AC_DM 8'h05
`define AC_LR 8'h06
`define AC_HR 8'h07
`define AC_AR 8'h08
`define AC_EM0 8'h10
`define AC_EMCUR 8'h18
// highest local word per area
`define LIM_IO 16'h01FF
`define LIM_LR 16'h003F
`define LIM_HR 16'h0063
`define LIM_AR 16'h001B
`define LIM_TC 16'h01FF
`define LIM_DM 16'h19FF
`define LIM_EM 16'h17FF
`endif

// ### pkg/ntc_pkg.sv
// types shared by the transfer decoder and its bench
// assumes ntc_defs.svh on the include path
`include "ntc_defs.svh"
package ntc_pkg;
   // memory areas, local and remote (direct mode)
   typedef enum logic [2:0] {
      A_IO = 3'h0, A_LR = 3'h1, A_HR = 3'h2, A_AR = 3'h3,
      A_TC = 3'h4, A_DM = 3'h5, A_EM = 3'h6
   } area_t;
   // controller states, one-hot
   typedef enum logic [7:0] {
      S_IDLE = 8'h01, S_CHK = 8'h02, S_PT0 = 8'h04, S_PT1 = 8'h08,
      S_PT2 = 8'h10, S_HDR = 8'h20, S_DATA = 8'h40, S_WAIT = 8'h80
   } state_t;
   // request header put on the link
   typedef struct packed {
      logic rd;              // read request, else write
      logic no_rsp;          // receiver must not answer
      logic level1;          // operating level 1, else 0
      logic [5:0] node;      // 0 = broadcast
      logic [2:0] unit;      // 0 controller, 1..4 applications
      logic [7:0] area_code; // remote area code
      logic [19:0] start;    // remote start word
      logic [8:0] count;     // words, 0..256
   } hdr_t;
endpackage : ntc_pkg

// ### hdl/network_transfer_control_decoder.sv
// network write/read transfer controller driven by three control words
// assumes a one-cycle-latency local memory and a valid/ready link port
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ntc_defs.svh"

// Notes on behaviour
// - time-out is field times 100 ms
// - field zero gives two second time-out
// - field all ones waits forever
// - retry count from bits 8-11
// - count 0..256, never more
// - node zero broadcasts write data
// - broadcast expects no response, no timer
// - bit 13 set on a write: no response, no wait
// - bit 15 must select this network
// - destination node 1..62 otherwise
// - own node number is refused
// - unit 0..4, bits 13-15 zero
// - bit 12 makes destination a pointer
// - pointer pair holds BCD start, area
// - area code translation table
// - local words out of range refused
// - bit 14 selects operating level
// - result held until next instruction
module network_transfer_control_decoder
   import ntc_pkg::*;
#(
   parameter int unsigned TICK_CYC = `TICK_MS * `CLK_KHZ // cycles per 100 ms
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // local memory
   output logic [15:0] mem_addr_o,
   output logic mem_rd_o,
   output logic mem_wr_o,
   output logic [15:0] mem_wdata_o,
   input wire logic [15:0] mem_rdata_i,
   // link request side
   output hdr_t hdr_o,
   output logic hdr_valid_o,
   input wire logic hdr_ready_i,
   output logic [15:0] tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   // link answer side
   input wire logic [15:0] rx_data_i,
   input wire logic rx_valid_i,
   input wire logic rsp_valid_i,
   input wire logic [7:0] rsp_code_i
);

   localparam logic [23:0] TICK_M1 = 24'(TICK_CYC - 1);
   localparam logic [7:0] DEF_TICKS = 8'(`DEF_TMO_MS / `TICK_MS);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] cw0_r, cw1_r, cw2_r, src_r, dst_r, node_r, area_r;
   logic [7:0] res_r;       // last result
   logic is_rd_r;           // current instruction is a read
   state_t st_r, st_nxt;
   logic [15:0] w0_r, w1_r; // pointer pair
   logic [8:0] cnt_r;       // words moved
   logic [3:0] rty_r;       // retries left
   logic pend_r;            // memory read in flight
   logic [15:0] txd_r;
   logic txv_r;
   logic [23:0] pre_r;      // 100 ms prescaler
   logic [7:0] tk_r;        // elapsed ticks
   logic mwr_r;
   logic [15:0] mwa_r, mwd_r;
   logic [15:0] rdata_r;

   // local word limit per area
   function automatic logic [15:0] lim_f(input logic [2:0] a);
      case (a)
         A_IO: lim_f = `LIM_IO;
         A_LR: lim_f = `LIM_LR;
         A_HR: lim_f = `LIM_HR;
         A_AR: lim_f = `LIM_AR;
         A_TC: lim_f = `LIM_TC;
         A_DM: lim_f = `LIM_DM;
         default: lim_f = `LIM_EM;
      endcase
   endfunction : lim_f

   // area to remote code
   function automatic logic [7:0] code_f(input logic [2:0] a);
      case (a)
         A_IO: code_f = `AC_IO;
         A_LR: code_f = `AC_LR;
         A_HR: code_f = `AC_HR;
         A_AR: code_f = `AC_AR;
         A_TC: code_f = `AC_TC;
         A_DM: code_f = `AC_DM;
         default: code_f = `AC_EMCUR;
      endcase
   endfunction : code_f

   // codes a pointer pair may carry
   function automatic logic code_ok_f(input logic [7:0] c);
      code_ok_f = (c == `AC_IO) || (c == `AC_TC) || (c == `AC_DM) || (c == `AC_LR) ||
         (c == `AC_HR) || (c == `AC_AR) || ((c >= `AC_EM0) && (c <= `AC_EMCUR));
   endfunction : code_ok_f

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire idle = (st_r == S_IDLE);
   wire wr_hit = wr_i && idle; // parameters frozen while busy
   wire go = wr_hit && (addr_i == `OFS_CMD) && (wdata_i[0] || wdata_i[1]);
   wire [8:0] len = cw0_r[8:0];
   wire bad_len = cw0_r > `MAX_WORDS;
   wire [7:0] node = cw2_r[7:0];
   wire bcast = (node == 8'h00) && !is_rd_r;
   wire bad_node = ((node == 8'h00) && is_rd_r) || (node > `MAX_NODE);
   wire self = (node != 8'h00) && (node == node_r[7:0]);
   wire bad_unit = (cw2_r[15:13] != 3'h0) || (cw2_r[12:8] > `MAX_UNIT);
   wire bad_net = !cw1_r[`CW1_NET];
   wire bad_area = (area_r[2:0] > A_EM) || (area_r[5:3] > A_EM);
   wire bad_par = bad_len || bad_node || bad_unit || bad_net || bad_area;
   // last local word, a zero count touches only the first
   wire [16:0] last_w = {1'b0, src_r} + 17'(len) - 17'(len != 9'h000);
   wire bad_rng = last_w > {1'b0, lim_f(area_r[2:0])};
   wire [7:0] chk_rc = self ? `RC_SELF : bad_par ? `RC_PARAM : bad_rng ? `RC_RANGE : `RC_OK;
   // reads always answer; broadcast never does
   wire need_rsp = is_rd_r || (!bcast && !cw1_r[`CW1_NORSP]);
   wire ptr_ok = code_ok_f(w0_r[15:8]);
   wire fetch = (st_r == S_DATA) && !pend_r && !txv_r && (cnt_r < len);
   wire dat_end = (st_r == S_DATA) && !pend_r && !txv_r && (cnt_r == len);
   wire rx_take = (st_r == S_WAIT) && rx_valid_i && (cnt_r < len);
   // time-out decode
   wire [7:0] tf = cw1_r[7:0];
   wire nolim = (tf == `TMO_NONE);
   wire [7:0] tlim = (tf == 8'h00) ? DEF_TICKS : tf;
   wire tick = (pre_r == TICK_M1);
   wire tmo = (st_r == S_WAIT) && !rsp_valid_i && !nolim && tick && (tk_r + 8'h01 == tlim);
   wire hdr_acc = (st_r == S_HDR) && hdr_ready_i;

   // register read mux
   wire [15:0] stat = {!idle, 3'h0, rty_r, res_r};
   wire [15:0] rmux =
      (addr_i == `OFS_CW0) ? cw0_r : (addr_i == `OFS_CW1) ? cw1_r :
      (addr_i == `OFS_CW2) ? cw2_r : (addr_i == `OFS_SRC) ? src_r :
      (addr_i == `OFS_DST) ? dst_r : (addr_i == `OFS_NODE) ? node_r :
      (addr_i == `OFS_AREA) ? area_r : (addr_i == `OFS_STAT) ? stat : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign rdata_o = rdata_r;
   assign hdr_valid_o = (st_r == S_HDR);
   assign hdr_o.rd = is_rd_r;
   assign hdr_o.no_rsp = !need_rsp;
   assign hdr_o.level1 = !cw1_r[`CW1_LVL0];
   assign hdr_o.node = cw2_r[5:0];
   assign hdr_o.unit = cw2_r[10:8];
   // pointer pair replaces the direct start
   assign hdr_o.area_code = cw1_r[`CW1_IND] ? w0_r[15:8] : code_f(area_r[5:3]);
   assign hdr_o.start = cw1_r[`CW1_IND] ? {w0_r[3:0], w1_r} : {4'h0, dst_r};
   assign hdr_o.count = len;
   assign tx_data_o = txd_r;
   assign tx_valid_o = txv_r;
   assign mem_rd_o = (st_r == S_PT0) || (st_r == S_PT1) || fetch;
   assign mem_wr_o = mwr_r;
   assign mem_wdata_o = mwd_r;
   assign mem_addr_o = mwr_r ? mwa_r : (st_r == S_PT0) ? dst_r :
      (st_r == S_PT1) ? dst_r + 16'h0001 : src_r + 16'(cnt_r);

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         S_IDLE: if (go) st_nxt = S_CHK;
         S_CHK: begin
            if (chk_rc != `RC_OK) st_nxt = S_IDLE;
            else if (cw1_r[`CW1_IND]) st_nxt = S_PT0;
            else st_nxt = S_HDR;
         end
         S_PT0: st_nxt = S_PT1;
         S_PT1: st_nxt = S_PT2;
         S_PT2: st_nxt = ptr_ok ? S_HDR : S_IDLE;
         S_HDR: if (hdr_ready_i) st_nxt = is_rd_r ? S_WAIT : S_DATA;
         S_DATA: if (dat_end) st_nxt = need_rsp ? S_WAIT : S_IDLE;
         S_WAIT: begin
            if (rsp_valid_i) st_nxt = S_IDLE;
            else if (tmo) st_nxt = (rty_r != 4'h0) ? S_HDR : S_IDLE;
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   // state and software registers
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= S_IDLE;
         cw0_r <= `RST_WORD;
         cw1_r <= `RST_CW1;
         cw2_r <= `RST_WORD;
         src_r <= `RST_WORD;
         dst_r <= `RST_WORD;
         node_r <= `RST_WORD;
         area_r <= `RST_WORD;
         is_rd_r <= 1'b0;
         rdata_r <= `RST_WORD;
      end else begin
         st_r <= st_nxt;
         if (rd_i) rdata_r <= rmux; // data one cycle later
         if (wr_hit && addr_i == `OFS_CW0) cw0_r <= wdata_i;
         if (wr_hit && addr_i == `OFS_CW1) cw1_r <= wdata_i;
         if (wr_hit && addr_i == `OFS_CW2) cw2_r <= wdata_i;
         if (wr_hit && addr_i == `OFS_SRC) src_r <= wdata_i;
         if (wr_hit && addr_i == `OFS_DST) dst_r <= wdata_i;
         if (wr_hit && addr_i == `OFS_NODE) node_r <= wdata_i;
         if (wr_hit && addr_i == `OFS_AREA) area_r <= wdata_i;
         if (go) is_rd_r <= !wdata_i[0]; // write wins if both set
      end
   end

   // result code: kept until the next instruction ends
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) res_r <= `RC_OK;
      else if (st_r == S_CHK && chk_rc != `RC_OK) res_r <= chk_rc;
      else if (st_r == S_PT2 && !ptr_ok) res_r <= `RC_PARAM;
      else if (dat_end && !need_rsp) res_r <= `RC_OK;
      else if (st_r == S_WAIT && rsp_valid_i) res_r <= rsp_code_i;
      else if (tmo && rty_r == 4'h0) res_r <= `RC_TMO;
   end

   // pointer pair, retry counter
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         w0_r <= `RST_WORD;
         w1_r <= `RST_WORD;
         rty_r <= 4'h0;
      end else begin
         if (st_r == S_PT1) w0_r <= mem_rdata_i;
         if (st_r == S_PT2) w1_r <= mem_rdata_i;
         if (st_r == S_CHK) rty_r <= cw1_r[`CW1_RTY_LO +: 4];
         else if (tmo && rty_r != 4'h0) rty_r <= rty_r - 4'h1;
      end
   end

   // word mover: memory to link, or link to memory
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r <= 9'h000;
         pend_r <= 1'b0;
         txv_r <= 1'b0;
         txd_r <= `RST_WORD;
         mwr_r <= 1'b0;
         mwa_r <= `RST_WORD;
         mwd_r <= `RST_WORD;
      end else begin
         pend_r <= fetch;
         mwr_r <= rx_take;
         if (st_r == S_HDR) cnt_r <= 9'h000; // a retry resends from the start
         else if ((txv_r && tx_ready_i) || rx_take) cnt_r <= cnt_r + 9'h001;
         if (pend_r) begin
            txd_r <= mem_rdata_i;
            txv_r <= 1'b1;
         end else if (tx_ready_i) begin
            txv_r <= 1'b0;
         end
         if (rx_take) begin
            mwa_r <= src_r + 16'(cnt_r);
            mwd_r <= rx_data_i;
         end
      end
   end

   // response timer, restarted with every header sent
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_r <= 24'h00_0000;
         tk_r <= 8'h00;
      end else if (hdr_acc) begin
         pre_r <= 24'h00_0000;
         tk_r <= 8'h00;
      end else if (st_r == S_WAIT) begin
         pre_r <= tick ? 24'h00_0000 : pre_r + 24'h00_0001;
         if (tick && tk_r != 8'hFF) tk_r <= tk_r + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   property p_len;
      (st_r == S_DATA) |-> (cnt_r <= len) && (len <= 9'h100);
   endproperty
   a_len: assert property (p_len) else $error("word count over limit");
   property p_bcast;
      (dat_end && bcast) |=> (st_r == S_IDLE) && (res_r == `RC_OK);
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast waited");
   property p_norsp;
      (dat_end && cw1_r[`CW1_NORSP] && !is_rd_r) |=> (st_r == S_IDLE);
   endproperty
   a_norsp: assert property (p_norsp) else $error("waited with response off");
   property p_self;
      (st_r == S_CHK && self) |=> (st_r == S_IDLE) && (res_r == `RC_SELF);
   endproperty
   a_self: assert property (p_self) else $error("own node not refused");
   property p_hdr;
      hdr_valid_o |-> cw1_r[`CW1_NET] && (cw2_r[7:0] <= `MAX_NODE) && (hdr_o.unit <= 3'h4);
   endproperty
   a_hdr: assert property (p_hdr) else $error("bad header sent");
   property p_level;
      hdr_valid_o |-> (hdr_o.level1 != cw1_r[`CW1_LVL0]);
   endproperty
   a_level: assert property (p_level) else $error("level bit wrong");
   property p_hold;
      (st_r == S_IDLE) |=> $stable(res_r);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed while idle");
   property p_forever;
      (st_r == S_WAIT && nolim) |-> !tmo;
   endproperty
   a_forever: assert property (p_forever) else $error("time-out with no limit");
   property p_retry;
      (tmo && rty_r != 4'h0) |=> (st_r == S_HDR) && (rty_r == $past(rty_r) - 4'h1);
   endproperty
   a_retry: assert property (p_retry) else $error("retry not taken");
   property p_tmo;
      (tmo && rty_r == 4'h0) |=> (st_r == S_IDLE) && (res_r == `RC_TMO) && (tk_r == tlim);
   endproperty
   a_tmo: assert property (p_tmo) else $error("time-out not reported");

endmodule : network_transfer_control_decoder
`default_nettype wire

// ### dv/ntc_link_model.sv
// remote node model: takes headers and words, returns read words and responses
// assumes the device's valid/ready link port on the same clock
`timescale 1ns/1ps
`default_nettype none
module ntc_link_model
   import ntc_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // requests from the device
   input wire hdr_t hdr_i,
   input wire logic hdr_valid_i,
   output logic hdr_ready_o,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   // answers to the device
   output logic [15:0] rx_data_o,
   output logic rx_valid_o,
   output logic rsp_valid_o,
   output logic [7:0] rsp_code_o,
   // bench control and view
   input wire logic mute_i,
   input wire logic slow_i,
   input wire logic [7:0] code_i,
   output hdr_t last_o,
   output logic [7:0] hdr_cnt_o
);
   hdr_t h; // header being served
   ////////////////////////////////////////////////////////////////
   // one request at a time, in link order
   initial begin
      {hdr_ready_o, tx_ready_o, rx_valid_o, rsp_valid_o} = 4'h0;
      rx_data_o = 16'h5A5A;
      rsp_code_o = 8'hFF;
      hdr_cnt_o = 8'h00;
      last_o = '0;
      forever begin
         @(posedge mclk_i);
         if (nrst_i && hdr_valid_i) begin
            // slow mode stalls the header a few cycles
            if (slow_i) repeat (3) @(posedge mclk_i);
            hdr_ready_o <= 1'b1;
            @(posedge mclk_i);
            h = hdr_i;
            hdr_ready_o <= 1'b0;
            last_o <= hdr_i;
            hdr_cnt_o <= hdr_cnt_o + 8'h01;
            for (int i = 0; i < 32'(h.count); i++) begin
               if (h.rd) begin
                  repeat (2) @(posedge mclk_i);
                  rx_valid_o <= 1'b1;
                  rx_data_o <= 16'hC000 + 16'(i);
                  @(posedge mclk_i);
                  rx_valid_o <= 1'b0;
                  // stale data would hide a late sample
                  rx_data_o <= 16'h3FFF - 16'(i);
               end else begin
                  do @(posedge mclk_i); while (!tx_valid_i);
                  tx_ready_o <= 1'b1;
                  @(posedge mclk_i);
                  tx_ready_o <= 1'b0;
               end
            end
            // silent on broadcast, on suppressed write, or when muted
            if (!mute_i && h.node != 6'h00 && (h.rd || !h.no_rsp)) begin
               repeat (2) @(posedge mclk_i);
               rsp_valid_o <= 1'b1;
               rsp_code_o <= code_i;
               @(posedge mclk_i);
               rsp_valid_o <= 1'b0;
               rsp_code_o <= ~code_i;
            end
         end
      end
   end
endmodule : ntc_link_model
`default_nettype wire

// ### dv/tb.sv
// self-checking bench: register tasks drive whole transfers against the node model
// assumes the package, its defines and the node model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ntc_defs.svh"
module tb
   import ntc_pkg::*;
;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] rdata_o, mem_addr_o, mem_wdata_o, tx_data_o, rx_data_i;
   logic [15:0] mem_rdata_i = 16'h0000;
   logic mem_rd_o, mem_wr_o, hdr_valid_o, hdr_ready_i, tx_valid_o, tx_ready_i;
   logic rx_valid_i, rsp_valid_i, mute_i = 1'b0, slow_i = 1'b0;
   logic [7:0] rsp_code_i, n, hcnt, code_i = 8'h5A;
   hdr_t hdr_o, last, eh;
   logic [15:0] mem [0:255]; // local words, low byte of address
   logic [15:0] txq [$]; // words seen on the link
   logic [15:0] st, dst = 16'h0123;
   logic [7:0] acode [0:6] = '{`AC_IO, `AC_LR, `AC_HR, `AC_AR, `AC_TC, `AC_DM, `AC_EMCUR};
   // cw0, cw1, cw2, src, cmd, result of refused transfers
   logic [79:0] bad [0:7] = '{80'h0101_8005_0105_0010_0101, 80'h0001_8005_013F_0010_0101,
      80'h0001_0005_0105_0010_0101, 80'h0001_8005_0505_0010_0101,
      80'h0001_8005_2105_0010_0101, 80'h0001_8005_0107_0010_0104,
      80'h0001_8005_0100_0010_0201, 80'h0002_8005_0105_19FF_0102};
   int fail_count = 0, check_count = 0, cyc = 0, t0 = 0, d, pn = 3000;
   ////////////////////////////////////////////////////////////////
   always #4 mclk_i = ~mclk_i;
   network_transfer_control_decoder #(.TICK_CYC(10)) dut (.mclk_i, .nrst_i, .addr_i,
      .wdata_i, .wr_i, .rd_i, .rdata_o, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o,
      .mem_rdata_i, .hdr_o, .hdr_valid_o, .hdr_ready_i, .tx_data_o, .tx_valid_o,
      .tx_ready_i, .rx_data_i, .rx_valid_i, .rsp_valid_i, .rsp_code_i);
   ntc_link_model link (.mclk_i, .nrst_i, .hdr_i(hdr_o), .hdr_valid_i(hdr_valid_o),
      .hdr_ready_o(hdr_ready_i), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
      .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .rsp_valid_o(rsp_valid_i),
      .rsp_code_o(rsp_code_i), .mute_i, .slow_i, .code_i, .last_o(last), .hdr_cnt_o(hcnt));
   ////////////////////////////////////////////////////////////////
   // local memory with inverse pattern when idle, link monitor, watchdog
   always @(posedge mclk_i) begin
      mem_rdata_i <= mem_rd_o ? mem[mem_addr_o[7:0]] : ~mem_rdata_i;
      if (mem_wr_o) mem[mem_addr_o[7:0]] <= mem_wdata_o;
      if (tx_valid_o && tx_ready_i) txq.push_back(tx_data_o);
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [63:0] s, e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(posedge mclk_i);
      v = rdata_o;
   endtask : rd
   // load the control words, start, poll status until idle or for pn reads
   task automatic run(input logic [15:0] c0, c1, c2, s, ar, cm);
      wr(`OFS_CW0, c0);
      wr(`OFS_CW1, c1);
      wr(`OFS_CW2, c2);
      wr(`OFS_SRC, s);
      wr(`OFS_DST, dst);
      wr(`OFS_AREA, ar);
      t0 = cyc;
      wr(`OFS_CMD, cm);
      st = 16'h8000;
      for (int k = 0; k < pn && st[15] !== 1'b0; k++) rd(`OFS_STAT, st);
   endtask : run
   task automatic finish_test();
      if (fail_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 16'h1000 + 16'(i);
      mem[8'h40] = 16'h0512; // pointer: area code, fifth digit
      mem[8'h41] = 16'h3456;
      mem[8'h42] = 16'h0912; // pointer with an area code no node knows
      repeat (8) @(posedge mclk_i);
      nrst_i <= 1'b1;
      rd(`OFS_CW1, st);
      chk("cw1 reset", st, `RST_CW1);
      rd(4'hF, st);
      chk("unmapped", st, 16'h0000);
      wr(`OFS_NODE, 16'h0007);
      // slow node, answered write, level 0
      slow_i <= 1'b1;
      run(16'h0002, 16'hC005, 16'h0105, 16'h0010, 16'h0015, 16'h0001);
      eh = '{1'b0, 1'b0, 1'b0, 6'h05, 3'h1, `AC_HR, 20'h00123, 9'h002};
      chk("header", last, eh);
      chk("result", st[7:0], 8'h5A);
      chk("words", {txq[0], txq[1], 16'(txq.size())}, 48'h1010_1011_0002);
      slow_i <= 1'b0;
      run(16'h0001, 16'hA005, 16'h0105, 16'h0010, 16'h0015, 16'h0001);
      chk("no answer", {last.no_rsp, last.level1, st[7:0]}, 10'h300);
      dst = 16'h0040;
      run(16'h0001, 16'h9005, 16'h0105, 16'h0010, 16'h0015, 16'h0001);
      chk("pointer", {last.area_code, last.start}, 28'h052_3456);
      // unknown pointer area code: refused before any header
      dst = 16'h0042;
      n = hcnt;
      run(16'h0001, 16'h9005, 16'h0105, 16'h0010, 16'h0015, 16'h0001);
      chk("bad pointer", {hcnt - n, st[7:0]}, {8'h00, `RC_PARAM});
      dst = 16'h0123;
      run(16'h0002, 16'h8005, 16'h0105, 16'h0020, 16'h0015, 16'h0002);
      chk("read", {last.rd, mem[8'h20], mem[8'h21]}, 33'h1_C000_C001);
      txq.delete();
      run(16'h0100, 16'h8005, 16'h0100, 16'h0000, 16'h0005, 16'h0001);
      chk("broadcast", {16'(txq.size()), st[7:0]}, 24'h01_0000);
      for (int a = 0; a < 7; a++) begin
         run(16'h0000, 16'h8005, 16'h0100, 16'h0010, 16'(a * 8 + 5), 16'h0001);
         chk("area code", {last.node, last.area_code}, {6'h00, acode[a]});
      end
      for (int b = 0; b < 8; b++) begin
         n = hcnt;
         run(bad[b][79:64], bad[b][63:48], bad[b][47:32], bad[b][31:16], 16'h0015,
            {8'h00, bad[b][15:8]});
         chk("refused", {hcnt - n, st[7:0]}, {8'h00, bad[b][7:0]});
      end
      // silent node: retry then time-out
      mute_i <= 1'b1;
      txq.delete();
      n = hcnt;
      run(16'h0001, 16'h8101, 16'h0105, 16'h0010, 16'h0015, 16'h0001);
      chk("retry", {hcnt - n, 8'(txq.size()), st[7:0]}, {8'h02, 8'h02, `RC_TMO});
      for (int f = 0; f < 2; f++) begin
         d = f ? 200 : 30;
         run(16'h0000, f ? 16'h8000 : 16'h8003, 16'h0105, 16'h0010, 16'h0015, 16'h0001);
         chk("wait time", (cyc - t0 >= d) && (cyc - t0 < d + 24), 1'b1);
      end
      pn = 100;
      run(16'h0000, 16'h80FF, 16'h0105, 16'h0010, 16'h0015, 16'h0001);
      chk("no limit", st[15], 1'b1);
      nrst_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b1;
      rd(`OFS_STAT, st);
      chk("status reset", st, 16'h0000);
      finish_test();
   end
endmodule : tb
`default_nettype wire
